// *** logic/socl_pkg.sv ***
// package for the safety output and case input logic
// assumes a single 40 MHz clock domain (mclk)
`default_nettype none
package socl_pkg;
  // clock rate and timing
  localparam int unsigned CLK_HZ          = 40_000_000;  // mclk rate
  localparam int unsigned CLK_PERIOD_NS   = 25;          // mclk period
  localparam int unsigned GRACE_TIME_MS   = 1000;        // further acceptance window
  localparam int unsigned GRACE_CYCLES    = GRACE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SWON_DELAY_MS   = 0;           // default switch-on delay
  localparam int unsigned SWON_CYCLES_RAW = SWON_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned SWON_CYCLES     = (SWON_CYCLES_RAW < 1) ? 1 : SWON_CYCLES_RAW;
  // widths
  localparam int unsigned N_CH      = 4;                 // raw case input channels
  localparam int unsigned CASE_W    = 3;                 // case number width
  localparam int unsigned CNT_W     = 32;                // timer width
  localparam logic [CASE_W-1:0] CASE_RST = 3'h0;         // case after reset
  // evaluation methods
  typedef enum logic [2:0] {
    SOCL_EV_COMPL,    // complementary pairs
    SOCL_EV_ONE_OF_N, // exactly one channel high
    SOCL_EV_PAR3,     // 3-channel parity
    SOCL_EV_PAR4      // 4-channel parity
  } socl_eval_e;
  // decoded case selection
  typedef struct packed {
    logic              valid;  // pattern legal
    logic [CASE_W-1:0] num;    // case number
  } socl_case_s;
  // safety output pair
  typedef struct packed {
    logic ch_b;  // second output of pair
    logic ch_a;  // first output of pair
  } socl_out_s;
endpackage : socl_pkg
`default_nettype wire

// *** logic/socl_top.sv ***
// case input decoding and safety switch output driver
// assumes inputs synchronous to mclk after two-stage chain, one clock domain
// What this block does
// - outputs ON when field clear, no fault
// - outputs OFF on object or fault
// - any detected error forces outputs OFF
// - control inputs select active monitoring case
// - method chosen by configuration
// - complementary input is two opposite channels
// - first high second low is 0, else 1
// - equal channel levels are an error
// - one-of-n: exactly one channel high
// - parity three or four channels, else error
// - hold case for delay, one-second grace
// - sequence monitoring: invalid after delay latches error
`default_nettype none
module socl_top
  import socl_pkg::*;
#(
  parameter int unsigned SWON_CNT  = SWON_CYCLES,  // switch-on delay in cycles
  parameter int unsigned GRACE_CNT = GRACE_CYCLES  // grace window in cycles
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  // configuration
  input  wire socl_pkg::socl_eval_e       eval_mode,
  input  wire logic                       seq_mon_en,
  // case input channels, pairs are first[0]/second[0] and first[1]/second[1]
  input  wire logic [socl_pkg::N_CH-1:0]  case_input_channel_first,
  input  wire logic [socl_pkg::N_CH-1:0]  case_input_channel_second,
  // field and fault status
  input  wire logic                       field_occupied,
  input  wire logic                       device_fault,
  input  wire logic                       xfer_error,
  // outputs
  output var  socl_pkg::socl_out_s        safety_switch_output,
  output var  socl_pkg::socl_case_s       active_case,
  output logic                            case_error,
  output logic                            restart_needed
);
  import socl_pkg::*;

  // selection states: run follows the pins, delay holds the old case,
  // grace waits for a legal pattern with outputs off, lock waits for reset
  typedef enum logic [1:0] {ST_RUN, ST_DELAY, ST_GRACE, ST_LOCK} socl_st_e;

  logic [N_CH-1:0] s1_first_q, s2_first_q;    // synchroniser, first channels
  logic [N_CH-1:0] s1_second_q, s2_second_q;  // synchroniser, second channels
  logic [N_CH-1:0] prev_first_q, prev_second_q; // last seen pattern
  socl_case_s      dec;                        // combinational decode
  socl_st_e        st_q;                       // selection state
  logic [CNT_W-1:0] cnt_q;                     // delay / grace timer
  logic            have_case_q;                // valid case held since reset
  logic            sel_bad;                    // selection currently unsafe
  logic            in_changed;                 // input pattern changed
  logic [1:0]      fill_q;                     // synchroniser fill marker

  // two-stage chain per channel
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_first_q  <= '0;
      s2_first_q  <= '0;
      s1_second_q <= '0;
      s2_second_q <= '0;
    end else begin
      s1_first_q  <= case_input_channel_first;
      s2_first_q  <= s1_first_q;
      s1_second_q <= case_input_channel_second;
      s2_second_q <= s1_second_q;
    end
  end

  // decode by configured method
  always_comb begin
    dec = '{valid: 1'b0, num: '0};
    case (eval_mode)
      SOCL_EV_COMPL: begin
        // two logical inputs from channel pairs 0 and 1
        dec.valid = (s2_first_q[0] ^ s2_second_q[0])
                  & (s2_first_q[1] ^ s2_second_q[1]);
        dec.num   = {1'b0, s2_second_q[1], s2_second_q[0]};
      end
      SOCL_EV_ONE_OF_N: begin
        // channels ordered first[0], second[0], first[1], second[1]
        case ({s2_second_q[1], s2_first_q[1], s2_second_q[0], s2_first_q[0]})
          4'h1: dec = '{valid: 1'b1, num: 3'h1};
          4'h2: dec = '{valid: 1'b1, num: 3'h2};
          4'h4: dec = '{valid: 1'b1, num: 3'h3};
          4'h8: dec = '{valid: 1'b1, num: 3'h4};
          default: dec = '{valid: 1'b0, num: 3'h0};
        endcase
      end
      SOCL_EV_PAR3: begin
        // first[0..1] data, first[2] parity; odd count of highs
        dec.valid = ^s2_first_q[2:0];
        dec.num   = {1'b0, s2_first_q[0], s2_first_q[1]};
      end
      SOCL_EV_PAR4: begin
        // first[0..2] data, first[3] parity; odd count of highs
        dec.valid = ^s2_first_q[3:0];
        dec.num   = {s2_first_q[2], s2_first_q[1], s2_first_q[0]};
      end
      default: dec = '{valid: 1'b0, num: 3'h0};
    endcase
  end

  assign in_changed = (s2_first_q != prev_first_q) | (s2_second_q != prev_second_q);

  // pattern history for change detection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_first_q  <= '0;
      prev_second_q <= '0;
    end else begin
      prev_first_q  <= s2_first_q;
      prev_second_q <= s2_second_q;
    end
  end

  // marks the synchroniser as filled two edges after reset release
  // without it the first delay decision would judge the reset zeros
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_q <= 2'h0;
    end else begin
      fill_q <= {fill_q[0], 1'b1};
    end
  end

  // case selection sequencer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q        <= ST_DELAY;
      cnt_q       <= '0;
      active_case <= '{valid: 1'b0, num: CASE_RST};
      have_case_q <= 1'b0;
    end else begin
      case (st_q)
        // run: follow the decoded case while the pins stay steady
        ST_RUN: begin
          if (in_changed || !dec.valid) begin
            st_q  <= ST_DELAY;  // old case kept
            cnt_q <= '0;
          end else begin
            active_case <= dec;
          end
        end
        // delay: old case kept for the switch-on delay
        ST_DELAY: begin
          if (!fill_q[1]) begin
            cnt_q <= '0;            // pins not yet through the chain
          end else if (cnt_q >= CNT_W'(SWON_CNT - 1)) begin
            cnt_q <= '0;
            if (dec.valid) begin
              st_q        <= ST_RUN;
              active_case <= dec;
              have_case_q <= 1'b1;
            end else if (seq_mon_en) begin
              st_q <= ST_LOCK;
            end else begin
              st_q <= ST_GRACE;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        // grace: outputs off, a legal pattern within the window recovers
        ST_GRACE: begin
          if (dec.valid) begin
            st_q        <= ST_RUN;
            active_case <= dec;
            have_case_q <= 1'b1;
          end else if (cnt_q >= CNT_W'(GRACE_CNT - 1)) begin
            st_q <= ST_LOCK;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        // lock: only a reset leaves this state
        ST_LOCK: begin
          active_case.valid <= 1'b0;  // stays until reset
        end
        default: st_q <= ST_LOCK;
      endcase
    end
  end

  // selection unsafe when grace, lock or nothing valid yet
  // in delay a held legal case keeps the outputs on until the decision
  assign sel_bad = (st_q == ST_GRACE) || (st_q == ST_LOCK) || !have_case_q
                 || ((st_q == ST_DELAY) && !active_case.valid);

  // status flags
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      case_error     <= 1'b0;
      restart_needed <= 1'b0;
    end else begin
      case_error     <= (st_q == ST_GRACE) || (st_q == ST_LOCK);
      restart_needed <= (st_q == ST_LOCK);
    end
  end

  // safety output pair
  // each off cause alone forces both channels low at the next mclk edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      safety_switch_output <= '{ch_b: 1'b0, ch_a: 1'b0};
    end else if (field_occupied || device_fault) begin
      safety_switch_output <= '{ch_b: 1'b0, ch_a: 1'b0};
    end else if (xfer_error || sel_bad) begin
      safety_switch_output <= '{ch_b: 1'b0, ch_a: 1'b0};
    end else begin
      safety_switch_output <= '{ch_b: 1'b1, ch_a: 1'b1};
    end
  end
endmodule : socl_top
`default_nettype wire

// *** verification/socl_properties.sv ***
// checker on the socl_top ports
// assumes one mclk domain, attached by the bind below
`default_nettype none
module socl_properties
  import socl_pkg::*;
(
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      sys_rst,
  // watched inputs
  input wire logic [socl_pkg::N_CH-1:0] case_input_channel_first,
  input wire logic [socl_pkg::N_CH-1:0] case_input_channel_second,
  input wire logic                      field_occupied,
  input wire logic                      device_fault,
  input wire logic                      xfer_error,
  // watched outputs
  input wire socl_pkg::socl_out_s       safety_switch_output,
  input wire socl_pkg::socl_case_s      active_case,
  input wire logic                      case_error,
  input wire logic                      restart_needed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // case pins unchanged for six cycles
  sequence s_quiet;
    ($stable(case_input_channel_first) && $stable(case_input_channel_second)) [*6];
  endsequence
  property p_pair; safety_switch_output.ch_a == safety_switch_output.ch_b; endproperty
  a_pair: assert property (p_pair) else $error("pair differs");
  property p_obj; field_occupied |=> safety_switch_output == 2'h0; endproperty
  a_obj: assert property (p_obj) else $error("on with object");
  property p_fault; device_fault |=> safety_switch_output == 2'h0; endproperty
  a_fault: assert property (p_fault) else $error("on with fault");
  property p_xfer; xfer_error |=> safety_switch_output == 2'h0; endproperty
  a_xfer: assert property (p_xfer) else $error("on with bad transfer");
  property p_err; case_error && $past(case_error) |-> safety_switch_output == 2'h0; endproperty
  a_err: assert property (p_err) else $error("on while case error");
  property p_lock; restart_needed |=> restart_needed && case_error; endproperty
  a_lock: assert property (p_lock) else $error("lock released");
  property p_lock_off; restart_needed |-> safety_switch_output == 2'h0; endproperty
  a_lock_off: assert property (p_lock_off) else $error("on while locked");
  property p_on;
    safety_switch_output.ch_a |->
      active_case.valid && $past(!field_occupied && !device_fault && !xfer_error);
  endproperty
  a_on: assert property (p_on) else $error("on without cause");
  property p_keep; s_quiet ##0 (active_case.valid && !case_error) |=> $stable(active_case); endproperty
  a_keep: assert property (p_keep) else $error("case moved, pins quiet");
endmodule : socl_properties
bind socl_top socl_properties u_props (
  .mclk(mclk), .sys_rst(sys_rst), .field_occupied(field_occupied),
  .case_input_channel_first(case_input_channel_first), .xfer_error(xfer_error),
  .case_input_channel_second(case_input_channel_second), .device_fault(device_fault),
  .safety_switch_output(safety_switch_output), .active_case(active_case),
  .case_error(case_error), .restart_needed(restart_needed)
);
`default_nettype wire

// *** verification/socl_partner.sv ***
// far-side safety controller watching the output pair
// assumes registered output levels on mclk
`default_nettype none
module socl_partner
  import socl_pkg::*;
#(
  parameter int unsigned DISC_CNT = 4  // tolerated disagreement, cycles
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // output pair, each channel on its own path
  input  wire socl_pkg::socl_out_s safety_switch_output,
  // controller view
  output logic                     machine_safe,
  output logic                     disc_fault
);
  int disc_q;  // cycles of disagreement
  // safe once either channel is off
  assign machine_safe = !safety_switch_output.ch_a || !safety_switch_output.ch_b;
  // discrepancy timer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      disc_q <= 0;
    end else begin
      disc_q <= (safety_switch_output.ch_a != safety_switch_output.ch_b) ? disc_q + 1 : 0;
    end
  end
  assign disc_fault = disc_q > DISC_CNT;
endmodule : socl_partner
`default_nettype wire

// *** verification/socl_top_tb.sv ***
// self-checking bench for socl_top with a reference decoder
// assumes a short grace window and one-cycle switch-on delay
`default_nettype none
module socl_top_tb
  import socl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, seq_mon_en, field_occupied, device_fault, xfer_error, bad;
  logic machine_safe, disc_fault, case_error, restart_needed;
  logic [N_CH-1:0] case_input_channel_first, case_input_channel_second;
  logic [31:0]     r;
  logic [31:0]     rng = 32'hfa09;
  socl_eval_e      eval_mode;
  socl_out_s       safety_switch_output;
  socl_case_s      active_case;
  int              fail_count = 0;
  int              num_checks = 0;
  socl_top #(.SWON_CNT(1), .GRACE_CNT(20)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .eval_mode(eval_mode), .seq_mon_en(seq_mon_en),
    .case_input_channel_first(case_input_channel_first),
    .case_input_channel_second(case_input_channel_second),
    .field_occupied(field_occupied), .device_fault(device_fault), .xfer_error(xfer_error),
    .safety_switch_output(safety_switch_output), .active_case(active_case),
    .case_error(case_error), .restart_needed(restart_needed));
  socl_partner u_ctrl (.mclk(mclk), .sys_rst(sys_rst), .safety_switch_output(safety_switch_output),
    .machine_safe(machine_safe), .disc_fault(disc_fault));
  // clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // reference decoder: {valid, case}
  function automatic logic [3:0] decode(logic [3:0] f, logic [3:0] s);
    logic [3:0] h;
    h = {s[1], f[1], s[0], f[0]};
    case (eval_mode)
      SOCL_EV_COMPL:    return {&(f[1:0] ^ s[1:0]), 1'b0, s[1:0]};
      SOCL_EV_ONE_OF_N: return {$countones(h) == 1, h[3] ? 3'h4 : h[2] ? 3'h3 : h[1] ? 3'h2 : 3'h1};
      SOCL_EV_PAR3:     return {^f[2:0], 1'b0, f[0], f[1]};
      default:          return {^f[3:0], f[2:0]};
    endcase
  endfunction : decode
  function automatic logic vld(logic [31:0] x);
    logic [3:0] d;
    d = decode(x[3:0], x[7:4]);
    return d[3];
  endfunction : vld
  task automatic check(string what, logic [3:0] exp, logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // reset with a legal pattern already on the pins
  task automatic do_reset(socl_eval_e m);
    sys_rst = 1'b1;
    eval_mode = m;
    bad = 1'b0;
    r = xs();
    while (!vld(r))
      r = xs();
    {case_input_channel_second, case_input_channel_first} = r[7:0];
    repeat (8) @(posedge mclk);
    #2 sys_rst = 1'b0;
    @(posedge mclk);
    #2 check("after_reset", 4'h0, {active_case.valid, 1'b0, safety_switch_output});
  endtask : do_reset
  // drive one pattern and status, compare once settled
  task automatic step(logic [3:0] f, logic [3:0] s, logic [2:0] st);
    logic [3:0] d;
    logic       on;
    d = decode(f, s);
    on = d[3] && st == 3'h0;
    @(posedge mclk);
    #2 {case_input_channel_first, case_input_channel_second} = {f, s};
    {field_occupied, device_fault, xfer_error} = st;
    repeat (12) @(posedge mclk);
    #2;
    if (d[3]) check("case", d, active_case);
    check("flags", {2'h0, !d[3], !d[3] && seq_mon_en}, {2'h0, case_error, restart_needed});
    check("outputs", {2'h0, on, on}, {2'h0, safety_switch_output});
    check("ctrl", {2'h0, 1'b0, !on}, {2'h0, disc_fault, machine_safe});
  endtask : step
  initial begin
    {sys_rst, seq_mon_en, field_occupied, device_fault, xfer_error} = 5'h10;
    eval_mode = SOCL_EV_COMPL;
    {case_input_channel_first, case_input_channel_second} = 8'h0;
    for (int k = 0; k < 8; k++) begin
      seq_mon_en = k[0];
      do_reset(socl_eval_e'(k >> 1));
      for (int i = 0; i < 16; i++) begin
        r = xs();
        // last random pattern legal, so the closing zeros start from run
        while ((bad || seq_mon_en || i == 15) && !vld(r))
          r = xs();
        bad = !vld(r);
        step(r[3:0], r[7:4], r[10:8] & {3{r[11]}});
      end
      step(4'h0, 4'h0, 3'h0);
      repeat (30) @(posedge mclk);
      #2 check("lock", 4'h3, {2'h0, case_error, restart_needed});
    end
    wrap_up();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule : socl_top_tb
`default_nettype wire
